// [msc_pkg.sv]
// package for the mode select and system control block
// assumes a single 40 MHz system clock; one state is one clock
package msc_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] MSC_IDX_MODE_STATUS = 16'hfff1;
    localparam logic [15:0] MSC_IDX_SYS_CTRL = 16'hfff2;
    localparam int unsigned MSC_ADDR_W = 18;

    // system control layout and reset value
    localparam logic [7:0] MSC_SYS_CTRL_RESET = 8'h0b;
    localparam int unsigned MSC_BIT_SLEEP_SELECT = 7;
    localparam int unsigned MSC_BIT_SETTLE_HI = 6;
    localparam int unsigned MSC_BIT_SETTLE_LO = 4;
    localparam int unsigned MSC_BIT_USER_ENABLE = 3;
    localparam int unsigned MSC_BIT_NMI_EDGE = 2;
    localparam int unsigned MSC_BIT_RESERVED_ONE = 1;
    localparam int unsigned MSC_BIT_RAM_ENABLE = 0;

    // mode status fixed bits: 7..6 read one, 5..3 read zero
    localparam logic [4:0] MSC_STATUS_FIXED = 5'h18;

    // settling waits in states (clock cycles)
    localparam int unsigned MSC_SETTLE_0 = 8192;
    localparam int unsigned MSC_SETTLE_1 = 16384;
    localparam int unsigned MSC_SETTLE_2 = 32768;
    localparam int unsigned MSC_SETTLE_3 = 65536;
    localparam int unsigned MSC_SETTLE_4 = 131072;
    localparam int unsigned MSC_CNT_W = 18;

    // strap capture waits for the synchroniser to fill
    localparam logic [1:0] MSC_STRAP_DELAY = 2'h2;

    typedef enum logic [2:0] {
        MSC_MODE_NONE = 3'h0,
        MSC_MODE_1 = 3'h1,
        MSC_MODE_2 = 3'h2,
        MSC_MODE_3 = 3'h3,
        MSC_MODE_4 = 3'h4
    } msc_mode_t;

    // gray along run -> standby -> settle and run <-> sleep; settle -> run flips both bits
    typedef enum logic [1:0] {
        MSC_PWR_RUN = 2'h0,
        MSC_PWR_STANDBY = 2'h1,
        MSC_PWR_SETTLE = 2'h3,
        MSC_PWR_SLEEP = 2'h2
    } msc_pwr_t;

    typedef struct packed {
        logic valid;
        logic addr_space_16m;
        logic initial_bus_16bit;
        msc_mode_t mode;
    } msc_mode_info_t;

    typedef struct packed {
        logic sleep_select;
        logic [2:0] settling_time_field;
        logic user_bit_enable;
        logic nonmaskable_edge_select;
        logic ram_enable;
    } msc_sys_ctrl_t;

endpackage

// [msc_settle_timer.sv]
// down counter that times the oscillator settling wait
// assumes the load value is nonzero and start is a one-cycle pulse
`timescale 1ns/1ps
module msc_settle_timer
    import msc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // control
    input wire logic i_start,
    input wire logic [MSC_CNT_W-1:0] i_load,
    // status
    output logic o_busy,
    output logic o_done
);

    logic [MSC_CNT_W-1:0] count;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
        end else if (i_start) begin
            count <= i_load;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // done marks the last cycle of the wait so the caller leaves on time
    always_comb begin
        o_busy = (count != '0);
        o_done = (count == {{(MSC_CNT_W-1){1'b0}}, 1'b1});
    end

endmodule

// [msc_ctrl.sv]
// mode select decoding and system control register bank
// assumes avalon-mm master on i_clk_sys, straps fixed in operation
// Contract
// - decode pins into modes one to four
// - bus eight bits only when all areas are
// - ram enable picks on-chip ram or external
// - mode status bits 7 and 6 read one
// - mode status bits 5 to 3 read zero
// - low status bits mirror pins at read
// - sleep select picks sleep or standby
// - sleep select kept after standby exit
// - settling field selects wait length
// - hold off for selected states after exit
// - user enable clear makes user bit a mask
// - edge select picks nmi falling or rising
// - control bit 1 reads one, not writable
// - ram enable loaded only at reset or by a write
// - control reset 0x0b, fixed register indices
// - exception entry sets mask bits
`timescale 1ns/1ps
module msc_ctrl
    import msc_pkg::*;
#(
    parameter int unsigned P_SETTLE_0 = MSC_SETTLE_0,
    parameter int unsigned P_SETTLE_1 = MSC_SETTLE_1,
    parameter int unsigned P_SETTLE_2 = MSC_SETTLE_2,
    parameter int unsigned P_SETTLE_3 = MSC_SETTLE_3,
    parameter int unsigned P_SETTLE_4 = MSC_SETTLE_4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // avalon-mm slave
    input wire logic [MSC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // mode strap pins
    input wire logic i_mode_pin_2,
    input wire logic i_mode_pin_1,
    input wire logic i_mode_pin_0,
    // bus and memory context
    input wire logic [7:0] i_area_8bit,
    input wire logic i_ram_region_hit,
    // cpu events
    input wire logic i_sleep_instr,
    input wire logic i_wake_event,
    input wire logic i_ext_irq,
    input wire logic i_exception_entry,
    input wire logic i_nmi_pin,
    // mode outputs
    output msc_mode_info_t o_mode_info,
    output logic o_bus_16bit,
    output logic o_ram_select,
    output logic o_external_select,
    // power state outputs
    output logic o_sleep_mode,
    output logic o_soft_standby,
    output logic o_hold_off,
    output logic o_settle_code_illegal,
    // cpu control outputs
    output logic o_user_bit_is_mask,
    output logic o_set_int_mask,
    output logic o_set_user_bit,
    output logic o_nmi_request
);

    localparam logic [MSC_ADDR_W-1:0] ADDR_STATUS =
        {MSC_IDX_MODE_STATUS, 2'b00};
    localparam logic [MSC_ADDR_W-1:0] ADDR_SYS_CTRL =
        {MSC_IDX_SYS_CTRL, 2'b00};

    msc_sys_ctrl_t sys_ctrl;
    msc_pwr_t pwr_state;
    msc_pwr_t next_pwr_state;

    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [1:0] strap_wait;
    logic strap_taken;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;

    logic req;
    logic take;
    logic ack;
    logic hit_status;
    logic hit_sys_ctrl;
    logic ctrl_write;
    logic [7:0] sys_ctrl_byte;
    logic [7:0] status_byte;

    logic settle_start;
    logic settle_done;
    logic [MSC_CNT_W-1:0] settle_load;

    // mode pins and nmi come from outside: two flops before use
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {i_mode_pin_2, i_mode_pin_1, i_mode_pin_0};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // idle level is high: a low reset value would fake an edge at release
            nmi_meta <= 1'b1;
            nmi_sync <= 1'b1;
            nmi_prev <= 1'b1;
        end else begin
            nmi_meta <= i_nmi_pin;
            nmi_sync <= nmi_meta;
            nmi_prev <= nmi_sync;
        end
    end

    // bus handshake: one wait cycle, answer on the following edge
    always_comb begin
        req = i_avs_read | i_avs_write;
        take = req & o_avs_waitrequest;
        ack = req & ~o_avs_waitrequest;
        hit_status = (i_avs_address == ADDR_STATUS);
        hit_sys_ctrl = (i_avs_address == ADDR_SYS_CTRL);
        // writes to the status word fall through here untouched
        ctrl_write = ack & i_avs_write & hit_sys_ctrl & i_avs_byteenable[0];
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~take;
        end
    end

    // pins are sampled at the read itself, not at reset
    always_comb begin
        status_byte = {MSC_STATUS_FIXED, pin_sync};
        sys_ctrl_byte = {sys_ctrl.sleep_select,
                         sys_ctrl.settling_time_field,
                         sys_ctrl.user_bit_enable,
                         sys_ctrl.nonmaskable_edge_select,
                         1'b1,
                         sys_ctrl.ram_enable};
    end

    // unmapped reads answer zero; unmapped writes are dropped
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (take & i_avs_read) begin
            if (hit_status) begin
                o_avs_readdata <= {24'h00_0000, status_byte};
            end else if (hit_sys_ctrl) begin
                o_avs_readdata <= {24'h00_0000, sys_ctrl_byte};
            end else begin
                o_avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // standby exit leaves sleep select alone; only a write or reset clears it.
    // ram enable lives here too: one driver, and standby never reloads it
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sys_ctrl.ram_enable <= MSC_SYS_CTRL_RESET[MSC_BIT_RAM_ENABLE];
            sys_ctrl.sleep_select <= MSC_SYS_CTRL_RESET[MSC_BIT_SLEEP_SELECT];
            sys_ctrl.settling_time_field <=
                MSC_SYS_CTRL_RESET[MSC_BIT_SETTLE_HI:MSC_BIT_SETTLE_LO];
            sys_ctrl.user_bit_enable <= MSC_SYS_CTRL_RESET[MSC_BIT_USER_ENABLE];
            sys_ctrl.nonmaskable_edge_select <= MSC_SYS_CTRL_RESET[MSC_BIT_NMI_EDGE];
        end else if (ctrl_write) begin
            sys_ctrl.sleep_select <= i_avs_writedata[MSC_BIT_SLEEP_SELECT];
            sys_ctrl.settling_time_field <=
                i_avs_writedata[MSC_BIT_SETTLE_HI:MSC_BIT_SETTLE_LO];
            sys_ctrl.user_bit_enable <= i_avs_writedata[MSC_BIT_USER_ENABLE];
            sys_ctrl.nonmaskable_edge_select <= i_avs_writedata[MSC_BIT_NMI_EDGE];
            sys_ctrl.ram_enable <= i_avs_writedata[MSC_BIT_RAM_ENABLE];
        end
    end

    // straps are caught once the synchroniser holds post-reset levels;
    // the board keeps them fixed, so later changes are not followed
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_wait <= 2'h0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            if (strap_wait == MSC_STRAP_DELAY) begin
                strap_taken <= 1'b1;
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    // invalid codes give an invalid mode with no address space
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mode_info <= '0;
        end else if (!strap_taken && strap_wait == MSC_STRAP_DELAY) begin
            unique case (pin_sync)
                3'h1: o_mode_info <= '{1'b1, 1'b0, 1'b0, MSC_MODE_1};
                3'h2: o_mode_info <= '{1'b1, 1'b0, 1'b1, MSC_MODE_2};
                3'h3: o_mode_info <= '{1'b1, 1'b1, 1'b0, MSC_MODE_3};
                3'h4: o_mode_info <= '{1'b1, 1'b1, 1'b1, MSC_MODE_4};
                default: o_mode_info <= '{1'b0, 1'b0, 1'b0, MSC_MODE_NONE};
            endcase
        end
    end

    // width follows the per-area configuration in every mode
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bus_16bit <= 1'b0;
        end else begin
            o_bus_16bit <= ~(&i_area_8bit);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ram_select <= 1'b0;
            o_external_select <= 1'b0;
        end else begin
            o_ram_select <= i_ram_region_hit & sys_ctrl.ram_enable;
            o_external_select <= i_ram_region_hit & ~sys_ctrl.ram_enable;
        end
    end

    // 10x codes share the longest wait; 11x is flagged and also
    // given the longest wait so a bad setting never shortens it
    always_comb begin
        unique case (sys_ctrl.settling_time_field)
            3'h0: settle_load = MSC_CNT_W'(P_SETTLE_0);
            3'h1: settle_load = MSC_CNT_W'(P_SETTLE_1);
            3'h2: settle_load = MSC_CNT_W'(P_SETTLE_2);
            3'h3: settle_load = MSC_CNT_W'(P_SETTLE_3);
            default: settle_load = MSC_CNT_W'(P_SETTLE_4);
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_settle_code_illegal <= 1'b0;
        end else begin
            o_settle_code_illegal <= &sys_ctrl.settling_time_field[2:1];
        end
    end

    always_comb begin
        settle_start = (pwr_state == MSC_PWR_STANDBY) & i_ext_irq;
    end

    msc_settle_timer u_settle (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_start(settle_start),
        .i_load(settle_load),
        .o_busy(),
        .o_done(settle_done)
    );

    always_comb begin
        next_pwr_state = pwr_state;
        unique case (pwr_state)
            MSC_PWR_RUN: begin
                if (i_sleep_instr) begin
                    if (sys_ctrl.sleep_select) begin
                        next_pwr_state = MSC_PWR_STANDBY;
                    end else begin
                        next_pwr_state = MSC_PWR_SLEEP;
                    end
                end
            end
            MSC_PWR_STANDBY: begin
                if (i_ext_irq) begin
                    next_pwr_state = MSC_PWR_SETTLE;
                end
            end
            MSC_PWR_SETTLE: begin
                if (settle_done) begin
                    next_pwr_state = MSC_PWR_RUN;
                end
            end
            MSC_PWR_SLEEP: begin
                if (i_wake_event) begin
                    next_pwr_state = MSC_PWR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwr_state <= MSC_PWR_RUN;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    // outputs registered from the next state so they track the state
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sleep_mode <= 1'b0;
            o_soft_standby <= 1'b0;
            o_hold_off <= 1'b0;
        end else begin
            o_sleep_mode <= (next_pwr_state == MSC_PWR_SLEEP);
            o_soft_standby <= (next_pwr_state == MSC_PWR_STANDBY);
            o_hold_off <= (next_pwr_state == MSC_PWR_SETTLE);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_user_bit_is_mask <= 1'b0;
            o_set_int_mask <= 1'b0;
            o_set_user_bit <= 1'b0;
        end else begin
            o_user_bit_is_mask <= ~sys_ctrl.user_bit_enable;
            o_set_int_mask <= i_exception_entry;
            o_set_user_bit <= i_exception_entry & ~sys_ctrl.user_bit_enable;
        end
    end

    // edge detect reads only the second and third flops
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_nmi_request <= 1'b0;
        end else if (sys_ctrl.nonmaskable_edge_select) begin
            o_nmi_request <= nmi_sync & ~nmi_prev;
        end else begin
            o_nmi_request <= ~nmi_sync & nmi_prev;
        end
    end

endmodule

// [msc_strap_board.sv]
// board straps for the mode pins, seen from outside the device
// assumes the bench only offers a new code while reset is held low
`timescale 1ns/1ps
module msc_strap_board
    import msc_pkg::*;
(
    // control from the bench
    input wire logic i_reset_n,
    input wire logic [2:0] i_code,
    // strap pins
    output logic o_mode_pin_2,
    output logic o_mode_pin_1,
    output logic o_mode_pin_0
);
    logic [2:0] pins = 3'h1;
    // straps only move under reset, and only to a supported mode
    always @(i_reset_n or i_code) begin
        if (!i_reset_n && i_code inside {3'h1, 3'h2, 3'h3, 3'h4}) begin
            pins = i_code;
        end
    end
    assign {o_mode_pin_2, o_mode_pin_1, o_mode_pin_0} = pins;
endmodule

// [msc_ctrl_sva.sv]
// assertions on the ports of the mode select and control block
// assumes one clock domain and straps held constant outside reset
`timescale 1ns/1ps
module msc_ctrl_sva
    import msc_pkg::*;
#(
    parameter int unsigned P_SETTLE_0 = MSC_SETTLE_0,
    parameter int unsigned P_SETTLE_1 = MSC_SETTLE_1,
    parameter int unsigned P_SETTLE_2 = MSC_SETTLE_2,
    parameter int unsigned P_SETTLE_3 = MSC_SETTLE_3,
    parameter int unsigned P_SETTLE_4 = MSC_SETTLE_4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register bus
    input wire logic [MSC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // straps and context
    input wire logic i_mode_pin_2,
    input wire logic i_mode_pin_1,
    input wire logic i_mode_pin_0,
    input wire logic [7:0] i_area_8bit,
    input wire logic i_ram_region_hit,
    input wire logic i_sleep_instr,
    input wire logic i_ext_irq,
    input wire logic i_exception_entry,
    // outputs under watch
    input wire msc_mode_info_t o_mode_info,
    input wire logic o_bus_16bit,
    input wire logic o_ram_select,
    input wire logic o_external_select,
    input wire logic o_sleep_mode,
    input wire logic o_soft_standby,
    input wire logic o_hold_off,
    input wire logic o_set_int_mask,
    input wire logic o_set_user_bit,
    input wire logic o_nmi_request
);
    localparam logic [17:0] A_ST = {MSC_IDX_MODE_STATUS, 2'b00};
    localparam logic [17:0] A_SC = {MSC_IDX_SYS_CTRL, 2'b00};
    logic st_ans;
    logic sc_ans;
    logic [MSC_CNT_W-1:0] hold_cnt;
    logic run;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    assign st_ans = !o_avs_waitrequest && i_avs_read && i_avs_address == A_ST;
    assign sc_ans = !o_avs_waitrequest && i_avs_read && i_avs_address == A_SC;
    assign run = !o_sleep_mode && !o_soft_standby && !o_hold_off;

    // length of the current hold-off, read at its falling edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= o_hold_off ? hold_cnt + 1'b1 : '0;
        end
    end

    mode_decode_a: assert property (o_mode_info.valid |-> o_mode_info.mode == {i_mode_pin_2, i_mode_pin_1,
        i_mode_pin_0} && o_mode_info.addr_space_16m == (o_mode_info.mode inside {MSC_MODE_3, MSC_MODE_4})
        && o_mode_info.initial_bus_16bit == (o_mode_info.mode inside {MSC_MODE_2, MSC_MODE_4}))
        else $error("mode decode mismatch");
    bus_width_a: assert property (##1 o_bus_16bit == ($past(i_area_8bit) != 8'hff))
        else $error("bus width wrong");
    ram_route_a: assert property (i_ram_region_hit |=> o_ram_select ^ o_external_select)
        else $error("ram hit not routed once");
    status_ones_a: assert property (st_ans |-> o_avs_readdata[7:6] == 2'b11)
        else $error("status top bits not one");
    status_zeros_a: assert property (st_ans |-> o_avs_readdata[5:3] == 3'h0)
        else $error("status middle bits not zero");
    status_mirror_a: assert property (st_ans |-> o_avs_readdata[2:0] == {i_mode_pin_2, i_mode_pin_1,
        i_mode_pin_0}) else $error("status does not mirror pins");
    ctrl_reserved_a: assert property (sc_ans |-> o_avs_readdata[1])
        else $error("control bit 1 not one");
    sleep_entry_a: assert property (i_sleep_instr && run |=> o_sleep_mode != o_soft_standby)
        else $error("sleep instruction not taken");
    standby_exit_a: assert property (o_soft_standby && i_ext_irq |=> o_hold_off && !o_soft_standby)
        else $error("standby exit without hold-off");
    hold_len_a: assert property ($fell(o_hold_off) |-> hold_cnt inside {P_SETTLE_0, P_SETTLE_1,
        P_SETTLE_2, P_SETTLE_3, P_SETTLE_4}) else $error("hold-off length not a settle count");
    hold_max_a: assert property (hold_cnt <= P_SETTLE_4)
        else $error("hold-off too long");
    exc_mask_a: assert property (i_exception_entry |=> o_set_int_mask)
        else $error("exception did not set mask");
    user_pair_a: assert property (o_set_user_bit |-> o_set_int_mask)
        else $error("user bit set alone");

    cover property (st_ans);
    cover property ($fell(o_hold_off));
    cover property (o_nmi_request);
endmodule

bind msc_ctrl msc_ctrl_sva #(.P_SETTLE_0(P_SETTLE_0), .P_SETTLE_1(P_SETTLE_1), .P_SETTLE_2(P_SETTLE_2),
    .P_SETTLE_3(P_SETTLE_3), .P_SETTLE_4(P_SETTLE_4)) u_msc_ctrl_sva (.i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_mode_pin_2(i_mode_pin_2),
    .i_mode_pin_1(i_mode_pin_1), .i_mode_pin_0(i_mode_pin_0), .i_area_8bit(i_area_8bit),
    .i_ram_region_hit(i_ram_region_hit), .i_sleep_instr(i_sleep_instr), .i_ext_irq(i_ext_irq),
    .i_exception_entry(i_exception_entry), .o_mode_info(o_mode_info), .o_bus_16bit(o_bus_16bit),
    .o_ram_select(o_ram_select), .o_external_select(o_external_select), .o_sleep_mode(o_sleep_mode),
    .o_soft_standby(o_soft_standby), .o_hold_off(o_hold_off), .o_set_int_mask(o_set_int_mask),
    .o_set_user_bit(o_set_user_bit), .o_nmi_request(o_nmi_request));

// [mode_select_system_control_test.sv]
// self-checking bench for the mode select and control block
// assumes short settle counts 8..128 and an avalon master with waits
`timescale 1ns/1ps
module mode_select_system_control_test import msc_pkg::*;;
    localparam logic [17:0] A_ST = {MSC_IDX_MODE_STATUS, 2'b00};
    localparam logic [17:0] A_SC = {MSC_IDX_SYS_CTRL, 2'b00};
    logic clk_sys, reset_n, rd, wr, p2, p1, p0, hit, slp, wake, irq, exc, nmi;
    logic [17:0] addr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] be;
    logic [2:0] code;
    logic [7:0] area, q;
    msc_mode_info_t minfo;
    logic wait_req, bus16, rsel, xsel, smode, sstby, hold, ill, uimask, setim, setub, nreq;
    int failures, samples_checked, sc, c_nmi, c_im, c_ub, n;
    int ns[$] = {8, 16, 32, 64, 128};

    msc_strap_board u_msc_strap_board (.i_reset_n(reset_n), .i_code(code), .o_mode_pin_2(p2),
        .o_mode_pin_1(p1), .o_mode_pin_0(p0));
    msc_ctrl #(.P_SETTLE_0(8), .P_SETTLE_1(16), .P_SETTLE_2(32), .P_SETTLE_3(64), .P_SETTLE_4(128)) u_msc_ctrl (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_mode_pin_2(p2), .i_mode_pin_1(p1), .i_mode_pin_0(p0), .i_area_8bit(area), .i_ram_region_hit(hit),
        .i_sleep_instr(slp), .i_wake_event(wake), .i_ext_irq(irq), .i_exception_entry(exc), .i_nmi_pin(nmi),
        .o_mode_info(minfo), .o_bus_16bit(bus16), .o_ram_select(rsel), .o_external_select(xsel),
        .o_sleep_mode(smode), .o_soft_standby(sstby), .o_hold_off(hold), .o_settle_code_illegal(ill),
        .o_user_bit_is_mask(uimask), .o_set_int_mask(setim), .o_set_user_bit(setub), .o_nmi_request(nreq));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 8; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    task automatic summarize();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [3:0] b);
        @(posedge clk_sys);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h00_0000, d};
        be <= b;
        // this wait ends when waitrequest is seen low; if it never is, the watchdog ends it
        do begin
            @(posedge clk_sys);
        end while (wait_req !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_ctrl(input logic [7:0] v);
        bus(1'b1, A_SC, v, 4'h1);
        sc = v | 8'h02;
    endtask

    task automatic rd_chk(input logic [17:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'h0);
        chk_reg(q, exp);
    endtask

    task automatic window(input int cyc);
        c_nmi = 0;
        c_im = 0;
        c_ub = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            c_nmi += nreq;
            c_im += setim;
            c_ub += setub;
        end
    endtask

    task automatic pulse_sleep();
        @(posedge clk_sys);
        slp <= 1'b1;
        @(posedge clk_sys);
        slp <= 1'b0;
        @(negedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        {rd, wr, hit, slp, wake, irq, exc, reset_n} = '0;
        {addr, wdata, be} = '0;
        nmi = 1'b1;
        code = 3'h1;
        area = 8'hff;
        seed = 32'h0001_741f;
        for (int m = 1; m <= 4; m++) begin
            @(posedge clk_sys);
            reset_n <= 1'b0;
            code <= m[2:0];
            repeat (20) @(posedge clk_sys);
            reset_n <= 1'b1;
            repeat (5) @(negedge clk_sys);
            chk_reg({5'h00, minfo.mode}, m[7:0]);
            chk_bit(minfo.addr_space_16m, m > 2);
            chk_bit(minfo.initial_bus_16bit, m % 2 == 0);
            rd_chk(A_ST, {5'h18, m[2:0]});
            rd_chk(A_SC, 8'h0b);
        end
        bus(1'b1, A_ST, 8'h00, 4'hf);
        rd_chk(A_ST, 8'hc4);
        bus(1'b1, A_SC, 8'h00, 4'h0);
        rd_chk(A_SC, 8'h0b);
        rd_chk(18'h0_0010, 8'h00);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr_ctrl(seed[7:0]);
            area <= (i == 0) ? 8'hff : seed[15:8];
            hit <= seed[16];
            rd_chk(A_SC, sc[7:0]);
            chk_bit(ill, sc[6:5] == 2'b11);
            chk_bit(uimask, !sc[3]);
            chk_bit(bus16, area != 8'hff);
            chk_bit(rsel, hit && sc[0]);
            chk_bit(xsel, hit && !sc[0]);
        end
        for (int e = 0; e < 2; e++) begin
            wr_ctrl(e ? 8'h0d : 8'h03);
            @(posedge clk_sys);
            nmi <= 1'b0;
            window(6);
            chk_bit(c_nmi == 1, e == 0);
            @(posedge clk_sys);
            nmi <= 1'b1;
            window(6);
            chk_bit(c_nmi == 1, e == 1);
            @(posedge clk_sys);
            exc <= 1'b1;
            @(posedge clk_sys);
            exc <= 1'b0;
            window(4);
            chk_bit(c_im == 1, 1'b1);
            chk_bit(c_ub == 1, e == 0);
        end
        wr_ctrl(8'h01);
        pulse_sleep();
        chk_bit(smode, 1'b1);
        @(posedge clk_sys);
        wake <= 1'b1;
        @(posedge clk_sys);
        wake <= 1'b0;
        @(negedge clk_sys);
        chk_bit(smode, 1'b0);
        // settle codes 0 to 6, illegal 110 included, which takes the longest wait
        for (int k = 0; k < 7; k++) begin
            wr_ctrl({1'b1, k[2:0], 4'h3});
            pulse_sleep();
            chk_bit(sstby, 1'b1);
            chk_bit(ill, k == 6);
            @(posedge clk_sys);
            irq <= 1'b1;
            @(posedge clk_sys);
            irq <= 1'b0;
            n = 0;
            forever begin
                @(negedge clk_sys);
                if (hold !== 1'b1 || n > 300) break;
                n++;
            end
            chk_reg(n[7:0], ns[k < 4 ? k : 4][7:0]);
            rd_chk(A_SC, sc[7:0]);
        end
        wr_ctrl(8'h0b);
        rd_chk(A_SC, 8'h0b);
        summarize();
    end
endmodule
